// file: rtl/ticl_loader.sv
// temperature indexed coefficient loader: memory, index, fetch and DAC registers
// assumes an 8-bit temperature code and its done strobe arrive synchronous to clk_sys
`timescale 1ns/10ps
`default_nettype none
`include "ticl_cfg.svh"
module ticl_loader #(
   parameter int TICK_CYCLES = `TICL_TICK_CYCLES,
   parameter int DEPTH = `TICL_MEM_DEPTH
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rstn,
   // temperature converter
   input wire logic [7:0] temp_code,
   input wire logic temp_valid,
   // calibration side
   input wire ticl_pkg::ticl_wr_t mem_wr,
   input wire logic lock_override,
   // dac registers
   output logic [15:0] offset_dac_register,
   output logic [15:0] span_dac_register,
   output logic [15:0] offset_tempco_register,
   output logic [15:0] span_tempco_register,
   output logic [3:0] coarse_gain,
   output logic [1:0] clip_select,
   // status
   output logic [7:0] temp_index_reg,
   output logic lock_engaged,
   output logic wr_refused
);
   logic [7:0] mem [0:DEPTH-1];
   logic [7:0] lock_byte;
   logic [7:0] rd_data;
   logic [9:0] rd_addr;
   logic [31:0] tick_reg, tick_next;
   ticl_pkg::ticl_state_t st_reg, st_next;
   logic [7:0] idx_next, hi_reg, hi_next;
   logic [7:0] fidx_reg, fidx_next;
   logic [15:0] ofs_reg, ofs_next, ofs_out_next, span_out_next;
   logic [15:0] otc_next, stc_next;
   logic [3:0] gain_next;
   logic [1:0] clip_next;
   logic lock_next, refuse_next, prot, tick;

   // coefficient memory; table reads are registered so each byte costs one cycle, tempco, config and lock byte reads are not
   always_ff @(posedge clk_sys) begin
      if (mem_wr.en && !refuse_next && mem_wr.addr < DEPTH[9:0]) begin
         mem[mem_wr.addr] <= mem_wr.data;
      end
      rd_data <= mem[rd_addr];
   end
   assign lock_byte = mem[`TICL_LOCK_ADDR];

   assign tick = (tick_reg == 32'(TICK_CYCLES - 1));
   // protected span: offset table, span words from 200h up, tempcos, configuration and user bytes
   assign prot = (mem_wr.addr <= `TICL_USER_HI) || (mem_wr.addr >= `TICL_SPAN_BASE);

   // address of the byte wanted next; span segment above 2FFh folds to 1A0h
   function automatic logic [9:0] span_addr(input logic [7:0] i, input logic lo);
      logic [9:0] a;
      a = `TICL_SPAN_BASE + {1'b0, i, lo};
      if (a >= `TICL_SPAN_SPLIT) begin
         a = a - `TICL_SPAN_SPLIT + `TICL_SPAN_WRAP;
      end
      return a;
   endfunction : span_addr

   always_comb begin
      tick_next = tick ? 32'h0 : tick_reg + 32'h1;
      st_next = st_reg;
      idx_next = temp_index_reg;
      hi_next = hi_reg;
      fidx_next = fidx_reg;
      ofs_next = ofs_reg;
      ofs_out_next = offset_dac_register;
      span_out_next = span_dac_register;
      otc_next = offset_tempco_register;
      stc_next = span_tempco_register;
      gain_next = coarse_gain;
      clip_next = clip_select;
      // any byte but the engage code, an unprogrammed one too, leaves the lock off
      lock_next = 1'b0;
      if ((lock_byte == `TICL_LOCK_ON) && !lock_override) begin
         lock_next = 1'b1;
      end
      refuse_next = mem_wr.en && prot && lock_engaged;
      rd_addr = `TICL_OFS_BASE;
      // index is the converter code clamped to the table, no wrap
      if (temp_valid) begin
         if (temp_code > `TICL_IDX_MAX) begin
            idx_next = `TICL_IDX_MAX;
         end else begin
            idx_next = temp_code;
         end
      end
      unique case (st_reg)
         ticl_pkg::ST_IDLE: begin
            if (tick && lock_engaged) begin
               // freeze the index so all four bytes come from one table row
               fidx_next = temp_index_reg;
               st_next = ticl_pkg::ST_OHI;
            end
         end
         ticl_pkg::ST_OHI: begin
            rd_addr = `TICL_OFS_BASE + {1'b0, fidx_reg, 1'b0};
            st_next = ticl_pkg::ST_OLO;
         end
         ticl_pkg::ST_OLO: begin
            rd_addr = `TICL_OFS_BASE + {1'b0, fidx_reg, 1'b1};
            hi_next = rd_data;
            st_next = ticl_pkg::ST_SHI;
         end
         ticl_pkg::ST_SHI: begin
            rd_addr = span_addr(fidx_reg, 1'b0);
            ofs_next = {hi_reg, rd_data};
            st_next = ticl_pkg::ST_SLO;
         end
         ticl_pkg::ST_SLO: begin
            rd_addr = span_addr(fidx_reg, 1'b1);
            hi_next = rd_data;
            st_next = ticl_pkg::ST_LOAD;
         end
         ticl_pkg::ST_LOAD: begin
            // both words land together, never half a code
            ofs_out_next = ofs_reg;
            span_out_next = {hi_reg, rd_data};
            otc_next = {mem[`TICL_OTC_ADDR], mem[`TICL_OTC_ADDR + 10'h1]};
            stc_next = {mem[`TICL_STC_ADDR], mem[`TICL_STC_ADDR + 10'h1]};
            gain_next = mem[`TICL_CFG_ADDR + 10'h1][`TICL_CFG_GAIN_LSB +: 4];
            clip_next = mem[`TICL_CFG_ADDR + 10'h1][`TICL_CFG_CLIP_LSB +: 2];
            st_next = ticl_pkg::ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         tick_reg <= 32'h0;
         st_reg <= ticl_pkg::ST_IDLE;
         temp_index_reg <= `TICL_IDX_MIN;
         fidx_reg <= `TICL_IDX_MIN;
         hi_reg <= 8'h00;
         ofs_reg <= 16'h0000;
         offset_dac_register <= 16'h0000;
         span_dac_register <= 16'h0000;
         offset_tempco_register <= 16'h0000;
         span_tempco_register <= 16'h0000;
         coarse_gain <= 4'h0;
         clip_select <= 2'h0;
         lock_engaged <= 1'b0;
         wr_refused <= 1'b0;
      end else begin
         tick_reg <= tick_next;
         st_reg <= st_next;
         temp_index_reg <= idx_next;
         fidx_reg <= fidx_next;
         hi_reg <= hi_next;
         ofs_reg <= ofs_next;
         offset_dac_register <= ofs_out_next;
         span_dac_register <= span_out_next;
         offset_tempco_register <= otc_next;
         span_tempco_register <= stc_next;
         coarse_gain <= gain_next;
         clip_select <= clip_next;
         lock_engaged <= lock_next;
         wr_refused <= refuse_next;
      end
   end

   property p_index_saturates;
      @(posedge clk_sys) disable iff (!rstn)
         temp_valid && temp_code > `TICL_IDX_MAX |=> temp_index_reg == `TICL_IDX_MAX;
   endproperty
   a_index_saturates: assert property (p_index_saturates) else $error("index not clamped");

   property p_index_never_high;
      @(posedge clk_sys) disable iff (!rstn) temp_index_reg <= `TICL_IDX_MAX;
   endproperty
   a_index_never_high: assert property (p_index_never_high) else $error("index past table");

   property p_index_follows;
      @(posedge clk_sys) disable iff (!rstn)
         temp_valid && temp_code <= `TICL_IDX_MAX |=> temp_index_reg == $past(temp_code);
   endproperty
   a_index_follows: assert property (p_index_follows) else $error("index not loaded");

   sequence s_fetch_start;
      st_reg == ticl_pkg::ST_IDLE && tick && lock_engaged;
   endsequence
   property p_fetch_runs;
      @(posedge clk_sys) disable iff (!rstn)
         s_fetch_start |-> ##5 st_reg == ticl_pkg::ST_LOAD;
   endproperty
   a_fetch_runs: assert property (p_fetch_runs) else $error("fetch did not run");

   property p_dac_atomic;
      @(posedge clk_sys) disable iff (!rstn)
         $changed(offset_dac_register) || $changed(span_dac_register)
         |-> $past(st_reg) == ticl_pkg::ST_LOAD;
   endproperty
   a_dac_atomic: assert property (p_dac_atomic) else $error("dac changed mid fetch");

   property p_no_fetch_unlocked;
      @(posedge clk_sys) disable iff (!rstn)
         st_reg == ticl_pkg::ST_IDLE && !lock_engaged |=> st_reg == ticl_pkg::ST_IDLE;
   endproperty
   a_no_fetch_unlocked: assert property (p_no_fetch_unlocked) else $error("fetch while unlocked");

   property p_refuse;
      @(posedge clk_sys) disable iff (!rstn)
         mem_wr.en && prot && lock_engaged |=> wr_refused;
   endproperty
   a_refuse: assert property (p_refuse) else $error("locked write not refused");

   property p_override;
      @(posedge clk_sys) disable iff (!rstn) lock_override |=> !lock_engaged;
   endproperty
   a_override: assert property (p_override) else $error("override ignored");

   sequence s_offset_bytes;
      st_reg == ticl_pkg::ST_OHI ##1 st_reg == ticl_pkg::ST_OLO;
   endsequence
   sequence s_span_bytes;
      st_reg == ticl_pkg::ST_SHI ##1 st_reg == ticl_pkg::ST_SLO;
   endsequence
   property p_fetch_order;
      @(posedge clk_sys) disable iff (!rstn)
         s_fetch_start |=> s_offset_bytes ##1 s_span_bytes ##1 st_reg == ticl_pkg::ST_LOAD;
   endproperty
   a_fetch_order: assert property (p_fetch_order) else $error("fetch steps out of order");

   property p_tick_bounded;
      @(posedge clk_sys) disable iff (!rstn)
         tick_reg < 32'(TICK_CYCLES);
   endproperty
   a_tick_bounded: assert property (p_tick_bounded) else $error("tick counter overran");

   property p_tick_wraps;
      @(posedge clk_sys) disable iff (!rstn)
         tick |=> tick_reg == 32'h0;
   endproperty
   a_tick_wraps: assert property (p_tick_wraps) else $error("tick counter did not wrap");

   property p_ofs_load;
      @(posedge clk_sys) disable iff (!rstn)
         st_reg == ticl_pkg::ST_LOAD |=> offset_dac_register == $past(ofs_reg);
   endproperty
   a_ofs_load: assert property (p_ofs_load) else $error("offset word not loaded");

   property p_fidx_stable;
      @(posedge clk_sys) disable iff (!rstn)
         st_reg != ticl_pkg::ST_IDLE |=> $stable(fidx_reg);
   endproperty
   a_fidx_stable: assert property (p_fidx_stable) else $error("index moved mid fetch");

   property p_dac_hold_unlocked;
      @(posedge clk_sys) disable iff (!rstn)
         st_reg == ticl_pkg::ST_IDLE && !lock_engaged |=> $stable(offset_dac_register) && $stable(span_dac_register);
   endproperty
   a_dac_hold_unlocked: assert property (p_dac_hold_unlocked) else $error("dac moved unlocked");

   property p_gain_only_on_load;
      @(posedge clk_sys) disable iff (!rstn)
         st_reg != ticl_pkg::ST_LOAD |=> $stable(coarse_gain) && $stable(clip_select);
   endproperty
   a_gain_only_on_load: assert property (p_gain_only_on_load) else $error("gain or clip moved");

   property p_tempco_only_on_load;
      @(posedge clk_sys) disable iff (!rstn)
         st_reg != ticl_pkg::ST_LOAD |=> $stable(offset_tempco_register) && $stable(span_tempco_register);
   endproperty
   a_tempco_only_on_load: assert property (p_tempco_only_on_load) else $error("tempco moved");

   property p_ofs_addr;
      @(posedge clk_sys) disable iff (!rstn)
         st_reg == ticl_pkg::ST_OHI || st_reg == ticl_pkg::ST_OLO |-> rd_addr < `TICL_OTC_ADDR;
   endproperty
   a_ofs_addr: assert property (p_ofs_addr) else $error("offset read outside table");

   property p_span_fold;
      @(posedge clk_sys) disable iff (!rstn)
         st_reg == ticl_pkg::ST_SHI || st_reg == ticl_pkg::ST_SLO |->
            rd_addr >= `TICL_SPAN_WRAP && rd_addr < `TICL_SPAN_SPLIT;
   endproperty
   a_span_fold: assert property (p_span_fold) else $error("span read outside table");

   property p_refuse_only_locked;
      @(posedge clk_sys) disable iff (!rstn)
         wr_refused |-> $past(lock_engaged) && $past(mem_wr.en);
   endproperty
   a_refuse_only_locked: assert property (p_refuse_only_locked) else $error("spurious refusal");

   property p_unlocked_accepts;
      @(posedge clk_sys) disable iff (!rstn)
         mem_wr.en && !lock_engaged |=> !wr_refused;
   endproperty
   a_unlocked_accepts: assert property (p_unlocked_accepts) else $error("unlocked write refused");

   property p_lock_follows_byte;
      @(posedge clk_sys) disable iff (!rstn)
         lock_byte == `TICL_LOCK_ON && !lock_override |=> lock_engaged;
   endproperty
   a_lock_follows_byte: assert property (p_lock_follows_byte) else $error("lock not engaged");

   property p_lock_needs_byte;
      @(posedge clk_sys) disable iff (!rstn)
         lock_engaged |-> $past(lock_byte) == `TICL_LOCK_ON && !$past(lock_override);
   endproperty
   a_lock_needs_byte: assert property (p_lock_needs_byte) else $error("lock engaged wrongly");

   property p_index_holds;
      @(posedge clk_sys) disable iff (!rstn)
         !temp_valid |=> $stable(temp_index_reg);
   endproperty
   a_index_holds: assert property (p_index_holds) else $error("index moved without result");
endmodule : ticl_loader
`default_nettype wire

// file: rtl/ticl_cfg.svh
// constants for the temperature indexed coefficient loader
// assumes a 20 MHz system clock and a byte-wide coefficient memory
// Notes on behaviour
// - every millisecond the offset word at the current index loads the offset DAC register.
// - offset table holds 176 sixteen-bit words, one per index value.
// - index never goes below 00h; colder keeps entry zero.
// - index saturates at AFh; hotter keeps last entry, never wraps.
// - span DAC register loads likewise from its own table, same saturation.
// - coarse gain selects one of sixteen steps.
// - clip limit selects one of four limit pairs.
// - offset and span tempco registers accept any 16-bit code.
// - coefficients live in a 768 by 8 memory with tables, tempcos, user bytes.
// - engaged lock refuses writes to coefficients and user bytes, except span words folded to 1A0h-1FFh.
// - high override pin defeats the lock so the tester can rewrite.
// - index comes from an 8-bit conversion each millisecond, held in a register.
// - each word is built from a high byte and the adjacent low byte.
// - lock engaged at FFh with override low; only then reloads run alone.
`ifndef TICL_CFG_SVH
`define TICL_CFG_SVH
`define TICL_CLK_HZ 20000000
`define TICL_PERIOD_MS 1
`define TICL_TICK_CYCLES ((`TICL_CLK_HZ / 1000) * `TICL_PERIOD_MS)
`define TICL_MEM_DEPTH 768
`define TICL_IDX_MIN 8'h00
`define TICL_IDX_MAX 8'haf
`define TICL_OFS_BASE 10'h000
`define TICL_SPAN_BASE 10'h200
`define TICL_SPAN_SPLIT 10'h300
`define TICL_SPAN_WRAP 10'h1a0
`define TICL_OTC_ADDR 10'h160
`define TICL_STC_ADDR 10'h162
`define TICL_CFG_ADDR 10'h164
`define TICL_LOCK_ADDR 10'h166
`define TICL_USER_LO 10'h168
`define TICL_USER_HI 10'h19b
`define TICL_LOCK_ON 8'hff
`define TICL_LOCK_OFF 8'h00
`define TICL_CFG_GAIN_LSB 0
`define TICL_CFG_CLIP_LSB 4
`endif

// file: rtl/ticl_pkg.sv
// types for the temperature indexed coefficient loader
// assumes ticl_cfg.svh is compiled alongside
`default_nettype none
package ticl_pkg;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_OHI = 3'b001,
      ST_OLO = 3'b010,
      ST_SHI = 3'b011,
      ST_SLO = 3'b100,
      ST_LOAD = 3'b101
   } ticl_state_t;
   typedef struct packed {
      logic en;
      logic [9:0] addr;
      logic [7:0] data;
   } ticl_wr_t;
endpackage : ticl_pkg
`default_nettype wire

// file: testbench/ticl_conv_model.sv
// behavioural model of the on-chip temperature converter
// assumes the loader samples temp_code on the edge where temp_valid is high
`timescale 1ns/10ps
`default_nettype none
module ticl_conv_model (
   // clock
   input wire logic clk_sys,
   // converter result
   output logic [7:0] temp_code,
   output logic temp_valid
);
   initial begin
      temp_code = 8'h00;
      temp_valid = 1'b0;
   end
   // gap lets the result arrive promptly or late
   task automatic convert(input logic [7:0] code, input int gap);
      repeat (gap) @(posedge clk_sys);
      @(posedge clk_sys);
      temp_code <= code;
      temp_valid <= 1'b1;
      @(posedge clk_sys);
      temp_valid <= 1'b0;
      // stale code must not look valid once the strobe drops
      temp_code <= ~code;
   endtask : convert
endmodule : ticl_conv_model
`default_nettype wire

// file: testbench/testbench.sv
// self-checking bench for the temperature indexed coefficient loader
// assumes ticl_pkg and the loader are compiled first; refresh shortened to 50 cycles
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin error_cnt++; \
   $display("wrong value at %0t: got %h expected %h", $time, (a), (e)); end end
module testbench;
   localparam int TICK = 50;
   logic clk_sys, rstn, lock_override, temp_valid, lock_engaged, wr_refused;
   logic [7:0] temp_code, temp_index_reg;
   logic [15:0] offset_dac_register, span_dac_register;
   logic [15:0] offset_tempco_register, span_tempco_register;
   logic [3:0] coarse_gain;
   logic [1:0] clip_select;
   ticl_pkg::ticl_wr_t mem_wr;
   int error_cnt = 0;
   int total_checks = 0;
   int cycles = 0;
   ticl_conv_model conv_i (.clk_sys(clk_sys), .temp_code(temp_code), .temp_valid(temp_valid));
   ticl_loader #(.TICK_CYCLES(TICK)) ticl_loader_i (
      .clk_sys(clk_sys), .rstn(rstn), .temp_code(temp_code), .temp_valid(temp_valid),
      .mem_wr(mem_wr), .lock_override(lock_override),
      .offset_dac_register(offset_dac_register), .span_dac_register(span_dac_register),
      .offset_tempco_register(offset_tempco_register),
      .span_tempco_register(span_tempco_register), .coarse_gain(coarse_gain),
      .clip_select(clip_select), .temp_index_reg(temp_index_reg),
      .lock_engaged(lock_engaged), .wr_refused(wr_refused));
   initial begin
      clk_sys = 1'b0;
      forever #25 clk_sys = ~clk_sys;
   end
   // hang guard well above the expected run length
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 3000) begin
         error_cnt++;
         wrap_up();
      end
   end
   task automatic wrap_up();
      if (error_cnt == 0 && total_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : wrap_up
   task automatic wr(input logic [9:0] addr, input logic [7:0] data);
      @(posedge clk_sys);
      mem_wr <= '{en: 1'b1, addr: addr, data: data};
      @(posedge clk_sys);
      mem_wr <= '{en: 1'b0, addr: ~addr, data: ~data};
   endtask : wr
   // two refresh periods plus the fetch guarantee at least one full load
   task automatic wait_refresh();
      repeat (2 * TICK + 10) @(posedge clk_sys);
      #1;
   endtask : wait_refresh
   task automatic t_index();
      conv_i.convert(8'h00, 0);
      @(posedge clk_sys);
      #1 `CHK(temp_index_reg, 8'h00)
      conv_i.convert(8'hff, 3);
      @(posedge clk_sys);
      #1 `CHK(temp_index_reg, 8'haf)
      conv_i.convert(8'h5a, 0);
      @(posedge clk_sys);
      #1 `CHK(temp_index_reg, 8'h5a)
      conv_i.convert(8'haf, 1);
      @(posedge clk_sys);
      #1 `CHK(temp_index_reg, 8'haf)
   endtask : t_index
   task automatic t_load();
      wr(10'h15e, 8'h12);
      wr(10'h15f, 8'h34);
      wr(10'h1fe, 8'h56);
      wr(10'h1ff, 8'h78);
      wr(10'h160, 8'hff);
      wr(10'h161, 8'hff);
      wr(10'h162, 8'h00);
      wr(10'h163, 8'h01);
      wr(10'h165, 8'h2b);
      wr(10'h166, 8'hff);
      repeat (3) @(posedge clk_sys);
      #1 `CHK(lock_engaged, 1'b1)
      wait_refresh();
      `CHK(offset_dac_register, 16'h1234)
      `CHK(span_dac_register, 16'h5678)
      `CHK(offset_tempco_register, 16'hffff)
      `CHK(span_tempco_register, 16'h0001)
      `CHK(coarse_gain, 4'hb)
      `CHK(clip_select, 2'h2)
   endtask : t_load
   task automatic t_lock();
      // the refusal flag stands for one cycle, right after the write edge
      wr(10'h15e, 8'haa);
      #1 `CHK(wr_refused, 1'b1)
      wait_refresh();
      `CHK(offset_dac_register, 16'h1234)
      @(posedge clk_sys);
      lock_override <= 1'b1;
      repeat (3) @(posedge clk_sys);
      #1 `CHK(lock_engaged, 1'b0)
      wr(10'h15e, 8'h9a);
      #1 `CHK(wr_refused, 1'b0)
      wait_refresh();
      `CHK(offset_dac_register, 16'h1234)
      @(posedge clk_sys);
      lock_override <= 1'b0;
      wait_refresh();
      `CHK(offset_dac_register, 16'h9a34)
      `CHK(span_dac_register, 16'h5678)
   endtask : t_lock
   // index zero picks the first entries; the span word there sits below the fold
   task automatic t_low();
      @(posedge clk_sys);
      lock_override <= 1'b1;
      wr(10'h000, 8'h0f);
      wr(10'h001, 8'hed);
      wr(10'h200, 8'hcb);
      wr(10'h201, 8'ha9);
      conv_i.convert(8'h00, 0);
      @(posedge clk_sys);
      lock_override <= 1'b0;
      wait_refresh();
      `CHK(temp_index_reg, 8'h00)
      `CHK(offset_dac_register, 16'h0fed)
      `CHK(span_dac_register, 16'hcba9)
   endtask : t_low
   initial begin
      rstn = 1'b0;
      lock_override = 1'b0;
      mem_wr = '0;
      repeat (6) @(posedge clk_sys);
      rstn <= 1'b1;
      #1 `CHK(lock_engaged, 1'b0)
      t_index();
      t_load();
      t_lock();
      t_low();
      wrap_up();
   end
endmodule : testbench
`default_nettype wire
